// *** rtl/cot_pkg.sv ***
// constants, types and states for the constant-on-time buck pulse and fault control
// assumes a single 20 MHz clock; all pin and comparator inputs are asynchronous
package cot_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
	localparam int unsigned DEGLITCH_US = 20;
	localparam int unsigned DEGLITCH_CYC = (DEGLITCH_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int unsigned MIN_OFF_NS = 200;
	localparam int unsigned MIN_OFF_CYC = (MIN_OFF_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned TON_INIT_NS = 400;
	localparam int unsigned PERIOD_NS = 2000;
	localparam int unsigned SS_SLEW_UV_PER_US = 5000;
	localparam int unsigned SS_TARGET_UV = 1_065_000;
	localparam int unsigned SS_US = SS_TARGET_UV / SS_SLEW_UV_PER_US;
	localparam int unsigned SS_CYC_DEF = SS_US * 1000 / CLK_NS;

	// ----------------------------------------
	// counter types and typed constants
	// ----------------------------------------
	typedef logic [7:0] cnt_t;
	typedef logic [3:0] fll_t;
	typedef logic [7:0] win_t;
	typedef logic [5:0] trim_t;
	typedef logic [8:0] dg_t;
	typedef logic [12:0] ss_t;
	localparam cnt_t CNT_ZERO = 8'h00;
	localparam cnt_t CNT_ONE = 8'h01;
	localparam cnt_t CNT_MAX = 8'hff;
	localparam cnt_t MIN_OFF_LD = cnt_t'(MIN_OFF_CYC - 1);
	localparam cnt_t TON_INIT = cnt_t'(TON_INIT_NS / CLK_NS);
	localparam cnt_t PERIOD_CNT = cnt_t'(PERIOD_NS / CLK_NS);
	localparam cnt_t TON_MIN = 8'h02;
	localparam cnt_t TON_MAX = 8'h1e;
	localparam fll_t FLL_ONE = 4'h1;
	localparam fll_t FLL_LAST = 4'hf;
	localparam win_t WIN_ONE = 8'h01;
	localparam win_t WIN_LAST = 8'hff;
	localparam win_t WIN_HALF = 8'h80;
	localparam trim_t TRIM_MID = 6'h20;
	localparam trim_t TRIM_MAX = 6'h3f;
	localparam trim_t TRIM_MIN = 6'h00;
	localparam trim_t TRIM_ONE = 6'h01;
	localparam dg_t DG_DONE = dg_t'(DEGLITCH_CYC);
	localparam dg_t DG_ONE = 9'h001;
	localparam ss_t SS_ONE = 13'h0001;

	// ----------------------------------------
	// rails and synchroniser layout
	// ----------------------------------------
	localparam int unsigned N_BUCK = 2;
	localparam int unsigned N_RAIL = 4;
	localparam int unsigned N_UV = 4;
	localparam int unsigned N_OV = 3;
	localparam int unsigned N_MON = N_UV + N_OV;
	localparam int unsigned RAIL_VDD1 = 0;
	localparam int unsigned RAIL_VDD2H = 1;
	localparam int unsigned RAIL_VDD2L = 2;
	localparam int unsigned RAIL_VDDQ = 3;
	localparam int unsigned OV_RAIL_OFS = 1;
	localparam int unsigned TRIM_W = 6;
	localparam int unsigned SY_EN = 0;
	localparam int unsigned SY_ENQ = 1;
	localparam int unsigned SY_VSEL = 2;
	localparam int unsigned SY_FB = 3;
	localparam int unsigned SY_VO = 5;
	localparam int unsigned SY_ZC = 7;
	localparam int unsigned SY_UV = 9;
	localparam int unsigned SY_OV = 13;
	localparam int unsigned SY_W = 16;

	// ----------------------------------------
	// switching phase states
	// ----------------------------------------
	typedef enum logic [1:0]
	{
		PH_IDLE = 2'b00,
		PH_ON = 2'b01,
		PH_MINOFF = 2'b10,
		PH_WAIT = 2'b11
	} phase_e;

endpackage

// *** rtl/cot_phase.sv ***
// one buck rail: on-time pulse sequencer, frequency lock and reference trim
// assumes comparator inputs already synchronised to clk
`timescale 1ns/1ps
module cot_phase
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// rail run enable
	input wire logic run,
	// synchronised comparators
	input wire logic fb_below,
	input wire logic valley_over,
	input wire logic zero_cross,
	// switch drive
	output logic hs_on,
	output logic ls_on,
	// reference trim code
	output cot_pkg::trim_t ref_trim
);
	import cot_pkg::*;

	phase_e st_q;
	cnt_t tmr_q, ton_q, per_q;
	fll_t fll_q;
	win_t win_q, acc_q;
	trim_t trim_q;
	logic hs_q, ls_q, dcm_q;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire stop = srst | ~run;
	wire tmr_done = tmr_q == CNT_ZERO;
	wire in_wait = st_q == PH_WAIT;
	wire fire = in_wait & fb_below & ~valley_over & ~stop;
	wire ls_cut = ls_q & zero_cross & ((st_q == PH_MINOFF) | (in_wait & ~fire & ~valley_over));
	wire fll_step = fire & ~dcm_q & (fll_q == FLL_LAST);
	wire ton_dn = fll_step & (per_q > PERIOD_CNT) & (ton_q > TON_MIN);
	wire ton_up = fll_step & (per_q < PERIOD_CNT) & (ton_q < TON_MAX);
	wire win_end = win_q == WIN_LAST;
	wire trim_up = win_end & (acc_q > WIN_HALF) & (trim_q != TRIM_MAX);
	wire trim_dn = win_end & (acc_q < WIN_HALF) & (trim_q != TRIM_MIN);
	wire cnt_t per_inc = (per_q != CNT_MAX) ? CNT_ONE : CNT_ZERO;

	assign hs_on = hs_q;
	assign ls_on = ls_q;
	assign ref_trim = trim_q;

	// ----------------------------------------
	// pulse sequencer
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (stop)
		begin
			st_q <= PH_IDLE;
			hs_q <= 1'b0;
			ls_q <= 1'b0;
			tmr_q <= CNT_ZERO;
		end
		else
		begin
			unique case (st_q)
				PH_IDLE: st_q <= PH_WAIT;
				PH_ON:
				begin
					tmr_q <= tmr_q - CNT_ONE;
					if (tmr_done)
					begin
						hs_q <= 1'b0;
						ls_q <= 1'b1;
						tmr_q <= MIN_OFF_LD;
						st_q <= PH_MINOFF;
					end
				end
				PH_MINOFF:
				begin
					tmr_q <= tmr_q - CNT_ONE;
					if (ls_cut)
						ls_q <= 1'b0;
					if (tmr_done)
						st_q <= PH_WAIT;
				end
				PH_WAIT:
				begin
					if (fire)
					begin
						hs_q <= 1'b1;
						ls_q <= 1'b0;
						tmr_q <= ton_q - CNT_ONE;
						st_q <= PH_ON;
					end
					else if (ls_cut)
						ls_q <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// frequency lock: slow on-time trim in ccm
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (stop)
		begin
			ton_q <= TON_INIT;
			per_q <= CNT_ZERO;
			fll_q <= '0;
			dcm_q <= 1'b0;
		end
		else
		begin
			per_q <= fire ? CNT_ZERO : per_q + per_inc;
			dcm_q <= fire ? 1'b0 : (dcm_q | ls_cut);
			if (fire & ~dcm_q)
				fll_q <= fll_q + FLL_ONE;
			if (ton_dn)
				ton_q <= ton_q - CNT_ONE;
			else if (ton_up)
				ton_q <= ton_q + CNT_ONE;
		end
	end

	// ----------------------------------------
	// average feedback loop: reference trim
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (stop)
		begin
			win_q <= '0;
			acc_q <= '0;
			trim_q <= TRIM_MID;
		end
		else
		begin
			win_q <= win_q + WIN_ONE;
			acc_q <= win_end ? win_t'(fb_below) : acc_q + win_t'(fb_below);
			if (trim_up)
				trim_q <= trim_q + TRIM_ONE;
			else if (trim_dn)
				trim_q <= trim_q - TRIM_ONE;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_no_overlap: assert property (@(posedge clk) disable iff (srst) !(hs_q && ls_q))
		else $error("high and low side on together");
	a_on_to_low: assert property (@(posedge clk) disable iff (srst) $fell(hs_q) && run |-> ls_q)
		else $error("low side not on after on-time");
	a_fire_cause: assert property (@(posedge clk) disable iff (srst)
		$rose(hs_q) |-> $past(in_wait && fb_below && !valley_over))
		else $error("pulse fired without conditions");
	a_valley_hold: assert property (@(posedge clk) disable iff (srst)
		in_wait && valley_over && ls_q && !stop |=> ls_q && !hs_q)
		else $error("low side released during valley limit");
	a_zero_cut: assert property (@(posedge clk) disable iff (srst) ls_cut && !stop |=> !ls_q)
		else $error("low side kept on after reversal");
	a_ton_range: assert property (@(posedge clk) disable iff (srst)
		ton_q >= TON_MIN && ton_q <= TON_MAX)
		else $error("on-time out of range");
	c_fire: cover property (@(posedge clk) disable iff (srst) fire);
	c_dcm: cover property (@(posedge clk) disable iff (srst) ls_cut);

endmodule

// *** rtl/cot_buck_pulse_and_fault_ctrl.sv ***
// top: input sync, rail enables, fault deglitch and latch, two buck phases
// assumes analog comparators and switch drivers outside, enable pins asynchronous
`timescale 1ns/1ps
module cot_buck_pulse_and_fault_ctrl
#(
	parameter int unsigned SS_CYCLES = cot_pkg::SS_CYC_DEF
)
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// control pins
	input wire logic en_pin,
	input wire logic en_q_pin,
	input wire logic vsel_pin,
	// buck comparators, index 0 is vdd2h, 1 is vddq
	input wire logic [cot_pkg::N_BUCK-1:0] fb_below,
	input wire logic [cot_pkg::N_BUCK-1:0] valley_over,
	input wire logic [cot_pkg::N_BUCK-1:0] zero_cross,
	// rail monitors
	input wire logic [cot_pkg::N_UV-1:0] uv_cmp,
	input wire logic [cot_pkg::N_OV-1:0] ov_cmp,
	// switch drive
	output logic [cot_pkg::N_BUCK-1:0] hs_on,
	output logic [cot_pkg::N_BUCK-1:0] ls_on,
	output logic [cot_pkg::N_BUCK*cot_pkg::TRIM_W-1:0] ref_trim,
	// rail control
	output logic [cot_pkg::N_RAIL-1:0] rail_en,
	output logic [cot_pkg::N_RAIL-1:0] discharge_en,
	output logic ss_busy,
	output logic vddq_hi_sel,
	// fault status
	output logic uv_fault,
	output logic ov_fault
);
	import cot_pkg::*;

	localparam ss_t SS_DONE = ss_t'(SS_CYCLES);

	logic [SY_W-1:0] meta_q, sync_q;
	logic [N_RAIL-1:0] rail_en_q, dis_q;
	logic [N_BUCK-1:0] run_q;
	logic uv_q, ov_q, rearm_q, ss_busy_q, vsel_q;
	ss_t ss_q;
	dg_t dg_q [N_MON];
	logic [N_MON-1:0] trip_w, gate_w;
	logic [N_RAIL-1:0] rail_on_w;

	// ----------------------------------------
	// input synchroniser
	// ----------------------------------------
	wire [SY_W-1:0] async_w = {ov_cmp, uv_cmp, zero_cross, valley_over, fb_below,
		vsel_pin, en_q_pin, en_pin};

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= async_w;
			sync_q <= meta_q;
		end
	end

	wire en_s = sync_q[SY_EN];
	wire enq_s = sync_q[SY_ENQ];
	wire [N_BUCK-1:0] fb_s = sync_q[SY_FB +: N_BUCK];
	wire [N_BUCK-1:0] vo_s = sync_q[SY_VO +: N_BUCK];
	wire [N_BUCK-1:0] zc_s = sync_q[SY_ZC +: N_BUCK];
	wire [N_MON-1:0] mon_s = {sync_q[SY_OV +: N_OV], sync_q[SY_UV +: N_UV]};

	// ----------------------------------------
	// fault deglitch, one counter per monitor
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < N_MON; g++)
		begin : mon
			if (g < N_UV)
			begin : uvg
				assign gate_w[g] = rail_en_q[g] & ~ss_busy_q;
			end
			else
			begin : ovg
				assign gate_w[g] = rail_en_q[g - N_UV + OV_RAIL_OFS];
			end
			assign trip_w[g] = dg_q[g] == DG_DONE;
			always_ff @(posedge clk)
			begin
				if (srst | ~(mon_s[g] & gate_w[g]))
					dg_q[g] <= '0;
				else if (!trip_w[g])
					dg_q[g] <= dg_q[g] + DG_ONE;
			end
		end
	endgenerate

	wire uv_trip = |trip_w[N_UV-1:0];
	wire ov_trip = |trip_w[N_MON-1:N_UV];
	wire fault = uv_q | ov_q;
	wire relatch_clr = rearm_q & en_s;

	// ----------------------------------------
	// fault latch and re-toggle detect
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			uv_q <= 1'b0;
			ov_q <= 1'b0;
			rearm_q <= 1'b0;
		end
		else
		begin
			uv_q <= uv_trip | (uv_q & ~relatch_clr);
			ov_q <= ov_trip | (ov_q & ~relatch_clr);
			rearm_q <= fault & ~relatch_clr & (rearm_q | ~en_s);
		end
	end

	// ----------------------------------------
	// rail enables, discharge and soft-start
	// ----------------------------------------
	generate
		for (g = 0; g < N_RAIL; g++)
		begin : rail
			if (g == RAIL_VDDQ)
			begin : q
				assign rail_on_w[g] = en_s & enq_s & ~fault;
			end
			else
			begin : m
				assign rail_on_w[g] = en_s & ~fault;
			end
		end
	endgenerate

	wire main_on = en_s & ~fault;
	wire ss_run = main_on & (ss_q != SS_DONE);

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rail_en_q <= '0;
			dis_q <= '1;
			run_q <= '0;
			ss_q <= '0;
			ss_busy_q <= 1'b0;
			vsel_q <= 1'b0;
		end
		else
		begin
			rail_en_q <= rail_on_w;
			dis_q <= ~rail_on_w;
			run_q <= {rail_on_w[RAIL_VDDQ], rail_on_w[RAIL_VDD2H]};
			ss_q <= !main_on ? '0 : (ss_run ? ss_q + SS_ONE : ss_q);
			ss_busy_q <= ss_run;
			vsel_q <= sync_q[SY_VSEL];
		end
	end

	assign rail_en = rail_en_q;
	assign discharge_en = dis_q;
	assign ss_busy = ss_busy_q;
	assign vddq_hi_sel = vsel_q;
	assign uv_fault = uv_q;
	assign ov_fault = ov_q;

	// ----------------------------------------
	// buck phases
	// ----------------------------------------
	generate
		for (g = 0; g < N_BUCK; g++)
		begin : buck
			cot_phase u_phase
			(
				.clk(clk),
				.srst(srst),
				.run(run_q[g]),
				.fb_below(fb_s[g]),
				.valley_over(vo_s[g]),
				.zero_cross(zc_s[g]),
				.hs_on(hs_on[g]),
				.ls_on(ls_on[g]),
				.ref_trim(ref_trim[g*TRIM_W +: TRIM_W])
			);
		end
	endgenerate

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_uv_shutdown: assert property (@(posedge clk) disable iff (srst)
		uv_trip |=> uv_fault ##1 (rail_en == '0 && discharge_en == '1))
		else $error("undervoltage did not shut rails");
	a_ov_shutdown: assert property (@(posedge clk) disable iff (srst)
		ov_trip |=> ov_fault ##1 (rail_en == '0 && discharge_en == '1) ##1 (hs_on == '0 && ls_on == '0))
		else $error("overvoltage did not stop switching");
	a_uv_latched: assert property (@(posedge clk) disable iff (srst)
		uv_q && !rearm_q |=> uv_q)
		else $error("undervoltage latch dropped without re-toggle");
	a_en_low_off: assert property (@(posedge clk) disable iff (srst)
		!en_s |=> rail_en == '0 && run_q == '0)
		else $error("rail on while enable low");
	a_retoggle_clear: assert property (@(posedge clk) disable iff (srst)
		fault && rearm_q && en_s && !uv_trip && !ov_trip |=> !uv_fault && !ov_fault)
		else $error("fault not cleared by re-toggle");
	a_ss_restart: assert property (@(posedge clk) disable iff (srst)
		$rose(rail_en[RAIL_VDD1]) |-> ss_busy)
		else $error("rail restarted without soft-start");
	a_trip_time: assert property (@(posedge clk) disable iff (srst)
		$rose(trip_w[0]) |-> $past(mon_s[0] && gate_w[0], 300))
		else $error("trip before deglitch time");
	c_uv: cover property (@(posedge clk) disable iff (srst) $rose(uv_fault));
	c_ov: cover property (@(posedge clk) disable iff (srst) $rose(ov_fault));
	c_rearm: cover property (@(posedge clk) disable iff (srst) fault ##1 !fault);

endmodule

// *** test/cot_plant.sv ***
// far-side model: switch stage, inductor current, feedback and rail comparators
// assumes controller outputs are registered on clk; comparator outputs are plain levels
`timescale 1ns/1ps
module cot_plant
(
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// controller drive
	input wire logic [cot_pkg::N_BUCK-1:0] hs_on,
	input wire logic [cot_pkg::N_BUCK-1:0] ls_on,
	input wire logic [cot_pkg::N_RAIL-1:0] rail_en,
	// bench commands
	input wire logic light,
	input wire logic valley_hold,
	input wire logic [cot_pkg::N_UV-1:0] uv_force,
	input wire logic [cot_pkg::N_OV-1:0] ov_force,
	// comparator outputs
	output logic [cot_pkg::N_BUCK-1:0] fb_below,
	output logic [cot_pkg::N_BUCK-1:0] valley_over,
	output logic [cot_pkg::N_BUCK-1:0] zero_cross,
	output logic [cot_pkg::N_UV-1:0] uv_cmp,
	output logic [cot_pkg::N_OV-1:0] ov_cmp
);
	import cot_pkg::*;

	// ----------------------------------------
	// off-time counters
	// ----------------------------------------
	cnt_t off_q [N_BUCK];
	wire cnt_t fb_dly = light ? 8'h3c : 8'h02;

	always_ff @(posedge clk)
	begin
		for (int i = 0; i < N_BUCK; i++)
		begin
			if (srst || hs_on[i])
				off_q[i] <= CNT_ZERO;
			else if (off_q[i] != CNT_MAX)
				off_q[i] <= off_q[i] + CNT_ONE;
		end
	end

	// ----------------------------------------
	// comparators
	// ----------------------------------------
	for (genvar i = 0; i < N_BUCK; i++)
	begin : g_cmp
		// light load drains the output slowly, so feedback drops late
		assign fb_below[i] = !hs_on[i] && (off_q[i] >= fb_dly);
		assign valley_over[i] = valley_hold && ls_on[i];
		assign zero_cross[i] = light && !hs_on[i] && (off_q[i] >= 8'h06);
	end
	// a rail that is off sits below its undervoltage level
	assign uv_cmp = uv_force | ~rail_en;
	assign ov_cmp = ov_force;
endmodule

// *** test/cot_buck_pulse_and_fault_ctrl_tb.sv ***
// self-checking bench for the buck pulse and fault control
// assumes cot_plant as far side and a short soft-start
`timescale 1ns/1ps
module cot_buck_pulse_and_fault_ctrl_tb;
	import cot_pkg::*;
	localparam int unsigned SS_SIM = 20;
	typedef struct packed {logic en; logic enq; logic vsel; logic [3:0] rails;} row_s;
	row_s rows [4] = '{'{1'h1, 1'h0, 1'h0, 4'h7}, '{1'h1, 1'h1, 1'h1, 4'hf},
		'{1'h0, 1'h1, 1'h1, 4'h0}, '{1'h1, 1'h1, 1'h0, 4'hf}};
	logic clk, srst, en_pin, en_q_pin, vsel_pin, light, valley_hold, drop;
	logic [N_BUCK-1:0] fb_below, valley_over, zero_cross, hs_on, ls_on;
	logic [N_UV-1:0] uv_cmp, uv_force;
	logic [N_OV-1:0] ov_cmp, ov_force;
	logic [N_BUCK*TRIM_W-1:0] ref_trim;
	logic [N_RAIL-1:0] rail_en, discharge_en;
	logic ss_busy, vddq_hi_sel, uv_fault, ov_fault;
	int failures, checks_done, on, per;

	// ----------------------------------------
	// instances
	// ----------------------------------------
	cot_buck_pulse_and_fault_ctrl #(.SS_CYCLES(SS_SIM)) dut (.clk(clk), .srst(srst),
		.en_pin(en_pin), .en_q_pin(en_q_pin), .vsel_pin(vsel_pin), .fb_below(fb_below),
		.valley_over(valley_over), .zero_cross(zero_cross), .uv_cmp(uv_cmp),
		.ov_cmp(ov_cmp), .hs_on(hs_on), .ls_on(ls_on), .ref_trim(ref_trim),
		.rail_en(rail_en), .discharge_en(discharge_en), .ss_busy(ss_busy),
		.vddq_hi_sel(vddq_hi_sel), .uv_fault(uv_fault), .ov_fault(ov_fault));
	cot_plant plant (.clk(clk), .srst(srst), .hs_on(hs_on), .ls_on(ls_on),
		.rail_en(rail_en), .light(light), .valley_hold(valley_hold),
		.uv_force(uv_force), .ov_force(ov_force), .fb_below(fb_below),
		.valley_over(valley_over), .zero_cross(zero_cross), .uv_cmp(uv_cmp),
		.ov_cmp(ov_cmp));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("counts: %0d checks, %0d failures", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// one full pulse of buck i: on length, period, low side dropped early
	task automatic meas(input int i, output int on, output int per, output logic drop);
		int w;
		w = 0;
		on = 0;
		drop = 1'h0;
		@(negedge clk);
		while (hs_on[i] === 1'h1 && w < 300)
		begin
			@(negedge clk);
			w++;
		end
		while (hs_on[i] !== 1'h1 && w < 300)
		begin
			@(negedge clk);
			w++;
		end
		while (hs_on[i] === 1'h1 && on < 300)
		begin
			chk(ls_on[i], 1'h0);
			@(negedge clk);
			on++;
		end
		chk(ls_on[i], 1'h1);
		per = on;
		while (hs_on[i] !== 1'h1 && per < 300)
		begin
			if (ls_on[i] === 1'h0)
				drop = 1'h1;
			@(negedge clk);
			per++;
		end
		chk(12'(per - on > MIN_OFF_CYC), 12'h1);
		chk(12'(w < 300 && per < 300), 12'h1);
	endtask

	// ----------------------------------------
	// clock and watchdog
	// ----------------------------------------
	initial
	begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	initial
	begin
		cyc(20000);
		failures++;
		complete_run();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		srst = 1'h1;
		{en_pin, en_q_pin, vsel_pin, light, valley_hold} = 5'h00;
		uv_force = 4'h0;
		ov_force = 3'h0;
		failures = 0;
		checks_done = 0;
		cyc(2);
		srst <= 1'h0;
		@(negedge clk);
		chk({hs_on, ls_on, rail_en, discharge_en}, 12'h00f);
		chk(ref_trim, 12'h820);
		chk({uv_fault, ov_fault, ss_busy}, 12'h0);
		$display("test reset done");
		foreach (rows[k])
		begin
			cyc(1);
			{en_pin, en_q_pin, vsel_pin} <= {rows[k].en, rows[k].enq, rows[k].vsel};
			cyc(6);
			@(negedge clk);
			chk({rail_en, discharge_en, 3'h0, vddq_hi_sel},
				{rows[k].rails, ~rows[k].rails, 3'h0, rows[k].vsel});
		end
		$display("test enable table done");
		cyc(1);
		srst <= 1'h1;
		cyc(2);
		srst <= 1'h0;
		@(negedge clk);
		chk({hs_on, ls_on, rail_en, discharge_en}, 12'h00f);
		chk({uv_fault, ov_fault, ss_busy, ref_trim[5:0]}, 12'h020);
		cyc(4);
		@(negedge clk);
		chk({ss_busy, rail_en}, 12'h01f);
		$display("test mid-run reset done");
		meas(0, on, per, drop);
		chk(12'(on), {4'h0, TON_INIT});
		chk(drop, 1'h0);
		$display("test pulse done");
		cyc(1200);
		meas(1, on, per, drop);
		chk(12'(on > TON_INIT), 12'h1);
		chk(12'(ref_trim[5:0] < TRIM_MID), 12'h1);
		$display("test loops done");
		cyc(1);
		valley_hold <= 1'h1;
		cyc(60);
		@(negedge clk);
		chk({hs_on, ls_on}, 12'h3);
		cyc(1);
		valley_hold <= 1'h0;
		meas(0, on, per, drop);
		$display("test valley done");
		cyc(1);
		light <= 1'h1;
		cyc(300);
		meas(0, on, per, drop);
		chk(drop, 1'h1);
		chk(12'(per >= 60), 12'h1);
		cyc(1);
		light <= 1'h0;
		cyc(1200);
		meas(0, on, per, drop);
		chk(12'(per <= 42), 12'h1);
		$display("test light load done");
		cyc(1);
		uv_force <= 4'h2;
		cyc(398);
		uv_force <= 4'h0;
		cyc(10);
		@(negedge clk);
		chk(uv_fault, 1'h0);
		for (int j = 0; j < N_MON; j++)
		begin
			cyc(1);
			uv_force <= (j < N_UV) ? 4'(1 << j) : 4'h0;
			ov_force <= (j < N_UV) ? 3'h0 : 3'(1 << (j - N_UV));
			cyc(400);
			@(negedge clk);
			chk({uv_fault, ov_fault}, 12'h0);
			cyc(4);
			@(negedge clk);
			chk({uv_fault, ov_fault, rail_en, discharge_en},
				{(j < N_UV) ? 2'h2 : 2'h1, 4'h0, 4'hf});
			cyc(2);
			@(negedge clk);
			chk({hs_on, ls_on}, 12'h0);
			cyc(1);
			uv_force <= 4'h0;
			ov_force <= 3'h0;
			cyc(30);
			@(negedge clk);
			chk({uv_fault | ov_fault, rail_en}, 12'h10);
			cyc(1);
			en_pin <= 1'h0;
			cyc(5);
			en_pin <= 1'h1;
			cyc(4);
			@(negedge clk);
			chk({uv_fault, ov_fault, ss_busy, rail_en}, 12'h01f);
			cyc(SS_SIM + 10);
		end
		$display("test faults done");
		complete_run();
	end
endmodule
